// [core/otpg_core.sv]
/*
 * Output test pattern generator: sits in the four-lane output datapath
 * and replaces image words by a constant, ramping or pseudo-random
 * pattern under register control, through a two-entry output buffer.
 * Assumes one clock, a synchronous active-low reset and a receiver that
 * may stall with pixOutReady low at any time.
 */
// Our own choice: strobed register access.
module otpg_core
    import otpg_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [REG_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [REG_W-1:0] regRdData,
    input wire otpg_word_type pixIn,
    input wire logic pixInValid,
    output logic pixInReady,
    output otpg_word_type pixOut,
    output logic pixOutValid,
    input wire logic pixOutReady
);

    logic [CTRL_W-1:0] ctrl_q;
    logic [REG_W-1:0] low01_q;
    logic [REG_W-1:0] low23_q;
    logic [REG_W-1:0] high_q;
    logic [REG_W-1:0] spareC_q;
    logic [LANES-1:0][WORD_W-1:0] ramp_q;
    logic [PRBS_W-1:0] prbs_q;
    logic [PRBS_W-1:0] prbs_d;
    otpg_word_type skid_q;
    logic skidValid_q;
    otpg_word_type srcWord;
    logic srcValid;
    logic fire;
    logic outLoad;
    logic insertOn;
    logic rampOn;
    logic prbsOn;
    logic testOn;
    logic framedOn;

    // Configured word of one lane: high bits over the lane's low byte
    function automatic logic [WORD_W-1:0] cfgWord(
        input logic [REG_W-1:0] low01,
        input logic [REG_W-1:0] low23,
        input logic [REG_W-1:0] high,
        input int lane
    );
        logic [LOW_W-1:0] lowByte;
        logic [HIGH_W-1:0] highBits;
        lowByte = '0;
        highBits = high[lane*HIGH_W +: HIGH_W];
        case (lane)
            0: lowByte = low01[0 +: LOW_W];
            1: lowByte = low01[LOW_W +: LOW_W];
            2: lowByte = low23[0 +: LOW_W];
            3: lowByte = low23[LOW_W +: LOW_W];
            default: lowByte = '0;
        endcase
        return {highBits, lowByte};
    endfunction

    // Write-strobe decode used by every writable register
    function automatic logic wrHit(
        input logic wr,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        return wr && (addr == target);
    endfunction

    assign insertOn = ctrl_q[BIT_INSERT];
    assign rampOn = ctrl_q[BIT_RAMP];
    assign prbsOn = ctrl_q[BIT_PRBS];
    assign framedOn = ctrl_q[BIT_FRAMED];
    assign testOn = insertOn || prbsOn;

    // Register writes

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q <= '0;
        end else if (wrHit(regWr, regAddr, ADDR_PATTERN_CONTROL)) begin
            ctrl_q <= regWrData[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            low01_q <= RST_PATTERN_LOW_01;
            low23_q <= RST_PATTERN_LOW_23;
        end else begin
            if (wrHit(regWr, regAddr, ADDR_PATTERN_LOW_01)) begin
                low01_q <= regWrData;
            end
            if (wrHit(regWr, regAddr, ADDR_PATTERN_LOW_23)) begin
                low23_q <= regWrData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            high_q <= RST_ZERO;
            spareC_q <= RST_SPARE_PATTERN_C;
        end else begin
            if (wrHit(regWr, regAddr, ADDR_PATTERN_HIGH)) begin
                high_q <= regWrData;
            end
            if (wrHit(regWr, regAddr, ADDR_SPARE_PATTERN_C)) begin
                spareC_q <= regWrData;
            end
        end
    end

    // Register reads: data stand in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            regRdData <= RST_ZERO;
        end else if (!regRd) begin
            regRdData <= RST_ZERO;
        end else begin
            case (regAddr)
                ADDR_SPARE_STATUS_A: regRdData <= RST_ZERO;
                ADDR_SPARE_STATUS_B: regRdData <= RST_ZERO;
                ADDR_SPARE_CONTROL_A: regRdData <= RST_ZERO;
                ADDR_SPARE_CONTROL_B: regRdData <= RST_SPARE_CONTROL_B;
                ADDR_PATTERN_CONTROL:
                    regRdData <= {{(REG_W-CTRL_W){1'b0}}, ctrl_q};
                ADDR_SPARE_PATTERN_A: regRdData <= RST_ZERO;
                ADDR_PATTERN_LOW_01: regRdData <= low01_q;
                ADDR_PATTERN_LOW_23: regRdData <= low23_q;
                ADDR_SPARE_PATTERN_B: regRdData <= RST_SPARE_PATTERN_B;
                ADDR_SPARE_PATTERN_C: regRdData <= spareC_q;
                ADDR_PATTERN_HIGH: regRdData <= high_q;
                ADDR_PATTERN_STATUS:
                    regRdData <= {{(REG_W-WORD_W){1'b0}}, ramp_q[0]};
                default: regRdData <= RST_ZERO;
            endcase
        end
    end

    // Source selection. Unframed test output runs free of the image
    // stream; incoming words are still accepted and dropped so the
    // upstream pipeline backs up only while the receiver stalls.
    assign srcValid = (testOn && !framedOn) ? 1'b1 : pixInValid;
    assign fire = srcValid && pixInReady;

    always_comb begin
        srcWord = pixIn;
        if (testOn) begin
            if (!framedOn) begin
                srcWord.frameValid = 1'b0;
                srcWord.lineValid = 1'b0;
            end
            for (int i = 0; i < LANES; i++) begin
                if (prbsOn) begin
                    srcWord.lane[i] = prbs_q[i +: WORD_W];
                end else if (rampOn) begin
                    srcWord.lane[i] = ramp_q[i];
                end else begin
                    srcWord.lane[i] =
                        cfgWord(low01_q, low23_q, high_q, i);
                end
            end
        end
    end

    // Ramp counters follow the configured word until the ramp runs,
    // so a ramp always starts from the value software last wrote.
    generate
        for (genvar g = 0; g < LANES; g++) begin : gRamp
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    ramp_q[g] <= '0;
                end else if (!(insertOn && rampOn) || prbsOn) begin
                    ramp_q[g] <= cfgWord(low01_q, low23_q, high_q, g);
                end else if (fire) begin
                    ramp_q[g] <= ramp_q[g] + 1'b1;
                end
            end
        end
    endgenerate

    assign prbs_d = {prbs_q[PRBS_W-2:0],
                     prbs_q[PRBS_TAP_A] ^ prbs_q[PRBS_TAP_B]};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prbs_q <= PRBS_SEED;
        end else if (prbsOn && fire) begin
            prbs_q <= prbs_d;
        end
    end

    // Two-entry buffer: output register plus skid register. Ready is
    // registered, so a word caught while the receiver stalls goes to
    // the skid entry instead of being lost.
    assign outLoad = !pixOutValid || pixOutReady;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pixOutValid <= 1'b0;
            pixOut <= '0;
        end else if (outLoad) begin
            if (skidValid_q) begin
                pixOutValid <= 1'b1;
                pixOut <= skid_q;
            end else begin
                pixOutValid <= fire;
                pixOut <= srcWord;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            skidValid_q <= 1'b0;
            skid_q <= '0;
        end else if (outLoad) begin
            skidValid_q <= 1'b0;
        end else if (fire) begin
            skidValid_q <= 1'b1;
            skid_q <= srcWord;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pixInReady <= 1'b0;
        end else begin
            pixInReady <= outLoad || !(skidValid_q || fire);
        end
    end

    // Checks

    sequence s_rampFire;
        fire && insertOn && rampOn && !prbsOn;
    endsequence

    sequence s_rampHeld;
        insertOn && rampOn && !prbsOn;
    endsequence

    property p_const_pattern;
        @(posedge clk) disable iff (!resetn)
        fire && insertOn && !rampOn && !prbsOn |->
            srcWord.lane[1] == {high_q[3:2], low01_q[15:8]} &&
            srcWord.lane[2] == {high_q[5:4], low23_q[7:0]};
    endproperty
    a_const_pattern: assert property (p_const_pattern)
        else $error("constant pattern word mismatch");

    property p_ramp_step;
        @(posedge clk) disable iff (!resetn)
        s_rampFire ##1 s_rampHeld |->
            ramp_q[3] == $past(ramp_q[3]) + 1'b1;
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("ramp did not advance by one");

    property p_ramp_source;
        @(posedge clk) disable iff (!resetn)
        s_rampFire |-> srcWord.lane[0] == ramp_q[0];
    endproperty
    a_ramp_source: assert property (p_ramp_source)
        else $error("ramp lane not driven by counter");

    property p_prbs_lane;
        @(posedge clk) disable iff (!resetn)
        fire && prbsOn |->
            srcWord.lane[3] == prbs_q[3 +: WORD_W] ##1
            prbs_q == $past(prbs_d);
    endproperty
    a_prbs_lane: assert property (p_prbs_lane)
        else $error("pseudo-random word or step wrong");

    property p_unframed;
        @(posedge clk) disable iff (!resetn)
        testOn && !framedOn |->
            srcValid && !srcWord.frameValid && !srcWord.lineValid;
    endproperty
    a_unframed: assert property (p_unframed)
        else $error("unframed test word carries frame flags");

    property p_framed;
        @(posedge clk) disable iff (!resetn)
        fire && testOn && framedOn |->
            srcWord.frameValid == pixIn.frameValid &&
            srcWord.lineValid == pixIn.lineValid;
    endproperty
    a_framed: assert property (p_framed)
        else $error("framed test word lost frame flags");

    property p_reset_values;
        @(posedge clk)
        !resetn |=> low01_q == RST_PATTERN_LOW_01 &&
            low23_q == RST_PATTERN_LOW_23 && high_q == RST_ZERO;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("pattern registers not at reset value");

    property p_high_bits;
        @(posedge clk) disable iff (!resetn)
        fire && insertOn && !rampOn && !prbsOn |->
            srcWord.lane[3][WORD_W-1 -: HIGH_W] == high_q[7:6];
    endproperty
    a_high_bits: assert property (p_high_bits)
        else $error("upper pattern bits not from high register");

    property p_stall_hold;
        @(posedge clk) disable iff (!resetn)
        pixOutValid && !pixOutReady |=>
            pixOutValid && $stable(pixOut);
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("output word changed during stall");

    property p_image_pass;
        @(posedge clk) disable iff (!resetn)
        fire && !testOn && outLoad && !skidValid_q |=>
            pixOutValid && pixOut == $past(pixIn);
    endproperty
    a_image_pass: assert property (p_image_pass)
        else $error("image word not passed through");

endmodule

// [core/otpg_pkg.sv]
/*
 * Shared constants and types of the output test pattern generator:
 * register map, reset values, field positions and the data word layout.
 * Assumes a 16-bit register port with an 8-bit word address.
 */
package otpg_pkg;

    localparam int LANES = 4;
    localparam int WORD_W = 10;
    localparam int LOW_W = 8;
    localparam int HIGH_W = 2;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;

    // Register word addresses
    localparam logic [7:0] ADDR_SPARE_STATUS_A = 8'h8a;
    localparam logic [7:0] ADDR_SPARE_STATUS_B = 8'h8b;
    localparam logic [7:0] ADDR_SPARE_CONTROL_A = 8'h8c;
    localparam logic [7:0] ADDR_SPARE_CONTROL_B = 8'h8d;
    localparam logic [7:0] ADDR_PATTERN_CONTROL = 8'h90;
    localparam logic [7:0] ADDR_SPARE_PATTERN_A = 8'h91;
    localparam logic [7:0] ADDR_PATTERN_LOW_01 = 8'h92;
    localparam logic [7:0] ADDR_PATTERN_LOW_23 = 8'h93;
    localparam logic [7:0] ADDR_SPARE_PATTERN_B = 8'h94;
    localparam logic [7:0] ADDR_SPARE_PATTERN_C = 8'h95;
    localparam logic [7:0] ADDR_PATTERN_HIGH = 8'h96;
    localparam logic [7:0] ADDR_PATTERN_STATUS = 8'h97;

    // Reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_SPARE_CONTROL_B = 16'hffff;
    localparam logic [15:0] RST_PATTERN_LOW_01 = 16'h0100;
    localparam logic [15:0] RST_PATTERN_LOW_23 = 16'h0302;
    localparam logic [15:0] RST_SPARE_PATTERN_B = 16'h0504;
    localparam logic [15:0] RST_SPARE_PATTERN_C = 16'h0706;

    // Control field positions
    localparam int BIT_INSERT = 0;
    localparam int BIT_RAMP = 1;
    localparam int BIT_PRBS = 2;
    localparam int BIT_FRAMED = 3;
    localparam int CTRL_W = 4;

    // Pseudo-random generator: x^15 + x^14 + 1
    localparam int PRBS_W = 15;
    localparam int PRBS_TAP_A = 14;
    localparam int PRBS_TAP_B = 13;
    localparam logic [14:0] PRBS_SEED = 15'h7fff;

    typedef struct packed {
        logic frameValid;
        logic lineValid;
        logic [LANES-1:0][WORD_W-1:0] lane;
    } otpg_word_type;

endpackage

// [testbench/otpg_receiver.sv]
/*
 * Receiver model for the pixel output of the test pattern generator:
 * accepts words and queues them for the bench to inspect.
 * Assumes the bench selects prompt or slow acceptance through slow.
 */
module otpg_receiver
    import otpg_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire otpg_word_type pixOut,
    input wire logic pixOutValid,
    input wire logic slow,
    output logic pixOutReady
);
    timeunit 1ns;
    timeprecision 1ps;
    otpg_word_type rxQ[$];
    logic [1:0] cnt_q;

    // Slow mode accepts one cycle in four, so the skid buffer fills up
    assign pixOutReady = !slow || (cnt_q == 2'h0);

    always @(posedge clk) begin
        if (!resetn) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            if (pixOutValid && pixOutReady) begin
                rxQ.push_back(pixOut);
            end
        end
    end
endmodule

// [testbench/otpg_test.sv]
/*
 * Self-checking bench of the output test pattern generator: register
 * accesses, pass-through, constant, ramp, pseudo-random, unframed modes.
 * Assumes the receiver model queues every accepted output word.
 */
module otpg_test
    import otpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WB = $bits(otpg_word_type);
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [REG_W-1:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [REG_W-1:0] regRdData;
    otpg_word_type pixIn = '0;
    logic pixInValid = 1'b0;
    logic pixInReady;
    otpg_word_type pixOut;
    logic pixOutValid;
    logic pixOutReady;
    logic slow = 1'b1;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;

    otpg_core otpg_core_inst (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .pixIn(pixIn), .pixInValid(pixInValid),
        .pixInReady(pixInReady), .pixOut(pixOut), .pixOutValid(pixOutValid),
        .pixOutReady(pixOutReady));
    otpg_receiver otpg_receiver_inst (.clk(clk), .resetn(resetn),
        .pixOut(pixOut), .pixOutValid(pixOutValid), .slow(slow),
        .pixOutReady(pixOutReady));

    always #10 clk = ~clk;

    // Whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("mismatch at %0t: run timed out", $time);
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [WB-1:0] got, exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got,
                exp);
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic regCheck(input logic [7:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        check(WB'(regRdData), WB'(exp), $sformatf("reg %h", a));
    endtask

    function automatic otpg_word_type inWord(input int k);
        otpg_word_type w;
        w.frameValid = 1'b1;
        w.lineValid = k[0];
        for (int i = 0; i < LANES; i++) begin
            w.lane[i] = WORD_W'(k * 37 + i * 101 + 5);
        end
        return w;
    endfunction

    // Sends n input words back to back, waiting on pixInReady
    task automatic sendWords(input int n);
        int t;
        for (int k = 0; k < n; k++) begin
            pixIn <= inWord(k);
            pixInValid <= 1'b1;
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (pixInReady !== 1'b1 && t < 200);
            if (t >= 200) begin
                check(WB'(0), WB'(1), "input never taken");
            end
        end
        pixInValid <= 1'b0;
    endtask

    task automatic waitWords(input int n);
        int t;
        t = 0;
        while (otpg_receiver_inst.rxQ.size() < n && t < 500) begin
            @(posedge clk);
            t++;
        end
        check(WB'(otpg_receiver_inst.rxQ.size() >= n), WB'(1), "word count");
    endtask

    // mode 0 pass, 1 constant, 2 ramp, 3 prbs; unframed clears flags
    task automatic expectWords(input int n, mode, input logic framed,
        input logic [15:0] lo01, lo23, hi, input string name);
        otpg_word_type e;
        logic [14:0] lfsr;
        logic [7:0] lo;
        lfsr = PRBS_SEED;
        waitWords(n);
        for (int k = 0; k < n; k++) begin
            e = inWord(k);
            for (int i = 0; i < LANES; i++) begin
                lo = (i < 2) ? lo01[i*8 +: 8] : lo23[(i-2)*8 +: 8];
                if (mode == 1 || mode == 2) begin
                    e.lane[i] = {hi[2*i +: 2], lo};
                    e.lane[i] = e.lane[i] + WORD_W'(mode == 2 ? k : 0);
                end else if (mode == 3) begin
                    e.lane[i] = lfsr[i +: WORD_W];
                end
            end
            if (!framed) begin
                e.frameValid = 1'b0;
                e.lineValid = 1'b0;
            end
            lfsr = {lfsr[13:0], lfsr[PRBS_TAP_A] ^ lfsr[PRBS_TAP_B]};
            check(otpg_receiver_inst.rxQ[k], e, name);
        end
        otpg_receiver_inst.rxQ.delete();
        $display("test %s done", name);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        regCheck(ADDR_PATTERN_CONTROL, 16'h0000);
        regCheck(ADDR_PATTERN_LOW_01, 16'h0100);
        regCheck(ADDR_PATTERN_LOW_23, 16'h0302);
        regCheck(ADDR_PATTERN_HIGH, 16'h0000);
        regCheck(ADDR_SPARE_CONTROL_B, 16'hffff);
        regCheck(ADDR_SPARE_PATTERN_B, 16'h0504);
        regCheck(ADDR_SPARE_STATUS_A, 16'h0000);
        regCheck(8'h40, 16'h0000);
        regCheck(ADDR_SPARE_PATTERN_C, 16'h0706);
        regWrite(ADDR_SPARE_PATTERN_C, 16'h1234);
        regCheck(ADDR_SPARE_PATTERN_C, 16'h1234);
        regWrite(ADDR_SPARE_CONTROL_B, 16'h0000);
        regCheck(ADDR_SPARE_CONTROL_B, 16'hffff);
        regWrite(ADDR_PATTERN_CONTROL, 16'hffff);
        regCheck(ADDR_PATTERN_CONTROL, 16'h000f);
        $display("test registers done");
        regWrite(ADDR_PATTERN_CONTROL, 16'h000c);
        sendWords(8);
        expectWords(8, 3, 1'b1, 0, 0, 0, "prbs");
        regWrite(ADDR_PATTERN_CONTROL, 16'h0000);
        regWrite(ADDR_PATTERN_LOW_01, 16'h5aa5);
        regWrite(ADDR_PATTERN_LOW_23, 16'hc33c);
        regWrite(ADDR_PATTERN_HIGH, 16'h00e4);
        regCheck(ADDR_PATTERN_LOW_01, 16'h5aa5);
        regCheck(ADDR_PATTERN_LOW_23, 16'hc33c);
        regWrite(ADDR_PATTERN_CONTROL, 16'h0009);
        sendWords(6);
        expectWords(6, 1, 1'b1, 16'h5aa5, 16'hc33c, 16'h00e4, "hold");
        regWrite(ADDR_PATTERN_CONTROL, 16'h0000);
        regWrite(ADDR_PATTERN_LOW_01, 16'hfffd);
        regWrite(ADDR_PATTERN_LOW_23, 16'h1080);
        regWrite(ADDR_PATTERN_HIGH, 16'h004f);
        regWrite(ADDR_PATTERN_CONTROL, 16'h000b);
        sendWords(7);
        expectWords(7, 2, 1'b1, 16'hfffd, 16'h1080, 16'h004f, "ramp");
        regCheck(ADDR_PATTERN_STATUS, 16'h0004);
        regWrite(ADDR_PATTERN_CONTROL, 16'h0000);
        sendWords(9);
        expectWords(9, 0, 1'b1, 0, 0, 0, "pass");
        slow <= 1'b0;
        regWrite(ADDR_PATTERN_CONTROL, 16'h0001);
        waitWords(6);
        regWrite(ADDR_PATTERN_CONTROL, 16'h0000);
        expectWords(6, 1, 1'b0, 16'hfffd, 16'h1080, 16'h004f, "free");
        results();
    end
endmodule
